// ==== include/adc_seq_map.svh ====
/*
  Named constants for the scan sequencer and its serial host: byte
  selectors, field positions, reset values, timing counts, host offsets.
  Assumes a 100 MHz mclk on both ends.
*/
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// ****************************************
// Clock modes and scan modes
// ****************************************
`define CK_PIN_SCAN 2'b00
`define CK_PIN_EACH 2'b01
`define CK_BYTE_SCAN 2'b10
`define CK_RESET 2'b10
`define SC_UP 2'b00
`define SC_FROM 2'b01
`define SC_REPEAT 2'b10

// ****************************************
// Byte selectors and fields
// ****************************************
`define SEL_SETUP 2'b01
`define SEL_AVG 3'b001
`define SEL_RST 4'b0001
`define RST_FIFO_BIT 3
`define AVG_ON_BIT 4
`define REG_ZERO 8'h00
`define CH_LAST 4'hF
`define PIN_INIT 4'b1010

// ****************************************
// Timing
// ****************************************
`define CLK_NS 10
`define CONV_NS 1000
`define CONV_CYCLES (`CONV_NS / `CLK_NS)
`define CNV_LOW_NS 40
`define CNV_LOW_MIN ((`CNV_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define SCLK_HALF 8

// ****************************************
// Host register words and command bits
// ****************************************
`define REG_CMD 2'h0
`define REG_CNV 2'h1
`define REG_STATUS 2'h2
`define REG_RX 2'h3
`define CMD_KEEP_BIT 8
`define CMD_ARM_BIT 9

`endif

// ==== include/adc_seq_pkg.sv ====
/*
  Types shared by the sequencer and its serial host.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package adc_seq_pkg;
  typedef enum logic {ST_IDLE, ST_CONV} dev_state_e;
  typedef enum logic [2:0] {H_IDLE, H_WAIT, H_SHIFT, H_GAP, H_PULSE} host_state_e;
endpackage
`default_nettype wire

// ==== include/adc_link_if.sv ====
/*
  Serial link between the converter and its host: clock, select, data
  both ways, convert-start and end-of-conversion, all active as named.
  Assumes both ends sample it on their own mclk.
*/
`timescale 1ns/100ps
`default_nettype none
interface adc_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic convert_start_n;
  logic eoc_n;
  modport device (input sclk, input cs_n, input din, input convert_start_n, output dout, output eoc_n);
  modport host (output sclk, output cs_n, output din, output convert_start_n, input dout, input eoc_n);
endinterface
`default_nettype wire

// ==== hw/sync_edge.sv ====
/*
  Two-stage synchroniser with edge detection for one pin.
  Assumes the pin is asynchronous to mclk and slower than mclk/4.
*/
`timescale 1ns/100ps
`default_nettype none
module sync_edge #(
  parameter logic INIT = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta;
  logic prev;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= INIT;
      level <= INIT;
      prev <= INIT;
    end else begin
      meta <= pin;
      level <= meta;
      prev <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule
`default_nettype wire

// ==== hw/adc_device.sv ====
/*
  Converter end: serial register port, scan and averaging sequencer,
  16-entry result FIFO and end-of-conversion flag.
  Assumes the host keeps its own timing rules on the link and that
  sample_in holds the converted value of mux_channel/temp_select.
*/
// Implementation choices: the register offsets and register access over Avalon-MM.
// Function
// R01 - Averaging byte carries 001 in top bits
// R02 - Averaging off means one conversion per result
// R03 - Depth field picks 4, 8, 16 or 32
// R04 - Repeat mode returns 4, 8, 12, 16 results
// R05 - Reset byte carries 0001, low bits ignored
// R06 - Reset bit set clears FIFO, else all registers
// R07 - Convert-start pulse runs a full scan
// R08 - End-of-conversion low until select or start falls
// R09 - Host waits for end-of-conversion before select
// R10 - Temperature result precedes channel results
// R11 - No new start pulse before end-of-conversion
// R12 - Per-pulse mode converts once per rising edge
// R13 - Host holds start low long enough
// R14 - Host waits end-of-conversion in per-pulse mode
// R15 - Per-pulse averaging pushes after enough pulses
// R16 - Temperature taken on first pulse after byte
// R17 - Conversion byte runs a full scan
// R18 - Power-up clock mode is byte-triggered
// R19 - Clock-select bits choose the start source
// R20 - Results are four zeros, twelve bits, MSB first
// R21 - Average is sum shifted right, truncated
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_map.svh"
module adc_device (
  input wire logic mclk,
  input wire logic rst_b,
  adc_link_if.device link,
  input wire logic [11:0] sample_in,
  output logic [3:0] mux_channel,
  output logic temp_select
);
  import adc_seq_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam logic [3:0] PIN_INIT = `PIN_INIT;
  logic [3:0] pin_raw;
  logic [3:0] pin_lvl;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  assign pin_raw = {link.convert_start_n, link.din, link.cs_n, link.sclk};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      sync_edge #(.INIT(PIN_INIT[gi])) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .pin(pin_raw[gi]),
        .level(pin_lvl[gi]),
        .rise(pin_rise[gi]),
        .fall(pin_fall[gi])
      );
    end
  endgenerate
  wire cs_low = ~pin_lvl[1];
  wire sclk_rise = pin_rise[0] & cs_low;
  wire sclk_fall = pin_fall[0] & cs_low;
  wire cs_fall = pin_fall[1];
  wire cnv_rise = pin_rise[3];
  wire cnv_fall = pin_fall[3];

  // ****************************************
  // Serial input and byte decode
  // ****************************************
  logic [7:0] in_sr;
  logic [2:0] in_cnt;
  logic follow_pend;
  logic follow_bip;
  logic [1:0] clk_mode;
  logic [4:0] avg_cfg;
  logic [7:0] bip_mask;
  logic [6:0] conv_cfg;
  wire [7:0] rx_byte = {in_sr[6:0], pin_lvl[2]};
  wire take_byte = sclk_rise && in_cnt == 3'h7;
  wire mode_byte = take_byte && follow_pend;
  wire cmd_byte = take_byte && !follow_pend;
  wire is_conv = cmd_byte && rx_byte[7];
  wire is_setup = cmd_byte && rx_byte[7:6] == `SEL_SETUP;
  // R01 averaging byte select
  wire is_avg = cmd_byte && rx_byte[7:5] == `SEL_AVG;
  // R05 reset byte, low bits unused
  wire is_rst = cmd_byte && rx_byte[7:4] == `SEL_RST;
  // R06 full reset or FIFO only
  wire soft_all = is_rst && !rx_byte[`RST_FIFO_BIT];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      in_sr <= `REG_ZERO;
      in_cnt <= 3'h0;
    end else if (!cs_low) begin
      in_cnt <= 3'h0;
    end else if (sclk_rise) begin
      in_sr <= rx_byte;
      in_cnt <= in_cnt + 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      // R18 power-up mode
      clk_mode <= `CK_RESET;
      avg_cfg <= 5'h00;
      bip_mask <= `REG_ZERO;
      conv_cfg <= 7'h00;
      follow_pend <= 1'b0;
      follow_bip <= 1'b0;
    end else if (soft_all) begin
      clk_mode <= `CK_RESET;
      avg_cfg <= 5'h00;
      bip_mask <= `REG_ZERO;
      conv_cfg <= 7'h00;
      follow_pend <= 1'b0;
      follow_bip <= 1'b0;
    end else begin
      if (is_setup) begin
        // R19 clock-select bits
        clk_mode <= rx_byte[5:4];
        follow_pend <= rx_byte[1];
        follow_bip <= rx_byte[0];
      end
      if (mode_byte) begin
        follow_pend <= 1'b0;
        bip_mask <= follow_bip ? (bip_mask | rx_byte) : (bip_mask & ~rx_byte);
      end
      if (is_avg) begin
        avg_cfg <= rx_byte[4:0];
      end
      if (is_conv) begin
        conv_cfg <= rx_byte[6:0];
      end
    end
  end

  // ****************************************
  // Scan decode and averaging arithmetic
  // ****************************************
  dev_state_e state;
  logic [6:0] conv_timer;
  logic [5:0] avg_cnt;
  logic [4:0] rep_cnt;
  logic signed [17:0] acc;
  logic eoc_n;
  wire [6:0] cur_cfg = is_conv ? rx_byte[6:0] : conv_cfg;
  wire [1:0] scan = cur_cfg[2:1];
  wire [3:0] first_ch = (scan == `SC_UP) ? 4'h0 : cur_cfg[6:3];
  wire [3:0] last_ch = (scan == `SC_FROM) ? `CH_LAST : cur_cfg[6:3];
  // R04 repeat count in repeat mode only
  wire [4:0] rep_target = (scan == `SC_REPEAT) ? 5'(({3'h0, avg_cfg[1:0]} + 5'h1) << 2) : 5'h1;
  wire avg_on = avg_cfg[`AVG_ON_BIT];
  // R02 R03 conversions per result
  wire [5:0] avg_target = avg_on ? 6'(6'h4 << avg_cfg[3:2]) : 6'h1;
  wire [2:0] avg_shift = avg_on ? 3'({1'b0, avg_cfg[3:2]} + 3'h2) : 3'h0;
  wire bipolar = !temp_select && bip_mask[~mux_channel[3:1]];
  wire signed [17:0] sample_ext = bipolar ? 18'(signed'(sample_in)) : {6'h00, sample_in};
  wire signed [17:0] acc_next = acc + sample_ext;
  // R21 truncating power-of-two divide
  wire signed [17:0] avg_val = acc_next >>> avg_shift;
  wire avg_done = (avg_cnt + 6'h1) == avg_target;
  wire last_rep = (rep_cnt + 5'h1) == rep_target;
  wire scan_end = avg_done && !temp_select && last_rep && mux_channel == last_ch;
  wire conv_end = state == ST_CONV && conv_timer == 7'h0;
  wire each_mode = clk_mode == `CK_PIN_EACH;
  wire done_evt = conv_end && (scan_end || each_mode);
  // R07 R17 whole-scan starts
  wire start_scan = state == ST_IDLE &&
    ((clk_mode == `CK_PIN_SCAN && cnv_rise) || (clk_mode == `CK_BYTE_SCAN && is_conv));
  // R12 one conversion per rising edge
  wire start_one = each_mode && cnv_rise && state == ST_IDLE;
  wire load_cursor = start_scan || (is_conv && each_mode);

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      conv_timer <= 7'h0;
      avg_cnt <= 6'h0;
      rep_cnt <= 5'h0;
      acc <= 18'h0;
      mux_channel <= 4'h0;
      temp_select <= 1'b0;
    end else if (soft_all) begin
      state <= ST_IDLE;
      avg_cnt <= 6'h0;
      rep_cnt <= 5'h0;
      acc <= 18'h0;
      mux_channel <= 4'h0;
      temp_select <= 1'b0;
    end else begin
      if (load_cursor) begin
        // R10 R16 temperature goes first
        mux_channel <= first_ch;
        temp_select <= cur_cfg[0];
        rep_cnt <= 5'h0;
        avg_cnt <= 6'h0;
        acc <= 18'h0;
      end
      if (start_scan || start_one) begin
        state <= ST_CONV;
        conv_timer <= 7'(`CONV_CYCLES);
      end else if (state == ST_CONV) begin
        if (conv_timer != 7'h0) begin
          conv_timer <= conv_timer - 7'h1;
        end else begin
          // R15 push after enough conversions
          if (!avg_done) begin
            acc <= acc_next;
            avg_cnt <= avg_cnt + 6'h1;
          end else begin
            acc <= 18'h0;
            avg_cnt <= 6'h0;
            rep_cnt <= 5'h0;
            if (temp_select) begin
              temp_select <= 1'b0;
            end else if (!last_rep) begin
              rep_cnt <= rep_cnt + 5'h1;
            end else if (mux_channel != last_ch) begin
              mux_channel <= mux_channel + 4'h1;
            end else begin
              mux_channel <= first_ch;
            end
          end
          if (scan_end || each_mode) begin
            state <= ST_IDLE;
          end else begin
            conv_timer <= 7'(`CONV_CYCLES);
          end
        end
      end
    end
  end

  // R08 end-of-conversion flag, set wins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      eoc_n <= 1'b1;
    end else if (done_evt) begin
      eoc_n <= 1'b0;
    end else if (cs_fall || (cnv_fall && !clk_mode[1]) || soft_all) begin
      eoc_n <= 1'b1;
    end
  end

  // ****************************************
  // Result FIFO and serial output
  // ****************************************
  logic [11:0] fifo_mem [16];
  logic [4:0] wr_ptr;
  logic [4:0] rd_ptr;
  logic [15:0] out_sr;
  logic [3:0] out_cnt;
  wire fifo_empty = wr_ptr == rd_ptr;
  wire fifo_full = (wr_ptr ^ rd_ptr) == 5'h10;
  wire push = conv_end && avg_done && !fifo_full;
  wire pop = sclk_rise && out_cnt == 4'hF && !fifo_empty;
  wire [11:0] head = fifo_empty ? 12'h000 : fifo_mem[rd_ptr[3:0]];

  always_ff @(posedge mclk) begin
    if (push) begin
      fifo_mem[wr_ptr[3:0]] <= avg_val[11:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= 5'h0;
      rd_ptr <= 5'h0;
    end else if (is_rst) begin
      wr_ptr <= 5'h0;
      rd_ptr <= 5'h0;
    end else begin
      wr_ptr <= push ? wr_ptr + 5'h1 : wr_ptr;
      rd_ptr <= pop ? rd_ptr + 5'h1 : rd_ptr;
    end
  end

  // R20 four zeros then result, MSB first
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_sr <= 16'h0000;
      out_cnt <= 4'h0;
    end else if (cs_fall) begin
      out_sr <= {4'h0, head};
      out_cnt <= 4'h0;
    end else if (sclk_rise) begin
      out_cnt <= out_cnt + 4'h1;
    end else if (sclk_fall) begin
      out_sr <= (out_cnt == 4'h0) ? {4'h0, head} : {out_sr[14:0], 1'b0};
    end
  end

  assign link.dout = out_sr[15];
  assign link.eoc_n = eoc_n;
endmodule
`default_nettype wire

// ==== hw/adc_host.sv ====
/*
  Serial host end: Avalon-MM slave with waitrequest takes commands,
  drives sclk, select, data and convert-start, and captures results.
  Assumes software polls the status word for busy and pending.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_map.svh"
module adc_host (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  adc_link_if.host link
);
  import adc_seq_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam logic [1:0] PIN_INIT = 2'b10;
  logic [1:0] pin_raw;
  logic [1:0] pin_lvl;
  logic [1:0] pin_fall;
  assign pin_raw = {link.eoc_n, link.dout};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      sync_edge #(.INIT(PIN_INIT[gi])) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .pin(pin_raw[gi]),
        .level(pin_lvl[gi]),
        .rise(),
        .fall(pin_fall[gi])
      );
    end
  endgenerate

  // ****************************************
  // Bus slave
  // ****************************************
  host_state_e state;
  logic pending;
  logic sclk;
  logic cs_n;
  logic din;
  logic cnv_n;
  logic [15:0] rx_sr;
  wire take = !avs_waitrequest;
  wire wr_cmd = avs_write && take && avs_address == `REG_CMD;
  wire wr_cnv = avs_write && take && avs_address == `REG_CNV;
  wire [31:0] status_word = {28'h0, cs_n, pin_lvl[1], pending, state != H_IDLE};
  wire [31:0] rd_mux = (avs_address == `REG_STATUS) ? status_word :
                       (avs_address == `REG_RX) ? {16'h0000, rx_sr} : 32'h0;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // ****************************************
  // Link sequencer
  // ****************************************
  logic [3:0] div_cnt;
  logic [2:0] bit_cnt;
  logic [7:0] tx_sr;
  logic [7:0] low_cnt;
  logic keep;
  logic arm;
  wire half_done = div_cnt == 4'(`SCLK_HALF - 1);
  wire [7:0] low_req = (avs_writedata[7:0] < 8'(`CNV_LOW_MIN)) ? 8'(`CNV_LOW_MIN) : avs_writedata[7:0];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= H_IDLE;
      pending <= 1'b0;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      din <= 1'b0;
      cnv_n <= 1'b1;
      rx_sr <= 16'h0000;
      div_cnt <= 4'h0;
      bit_cnt <= 3'h0;
      tx_sr <= `REG_ZERO;
      low_cnt <= `REG_ZERO;
      keep <= 1'b0;
      arm <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
      if (pin_fall[1]) begin
        pending <= 1'b0;
      end
      case (state)
        H_IDLE: begin
          if (wr_cmd) begin
            tx_sr <= avs_writedata[7:0];
            keep <= avs_writedata[`CMD_KEEP_BIT];
            arm <= avs_writedata[`CMD_ARM_BIT];
            state <= H_WAIT;
          end else if (wr_cnv && !pending && cs_n) begin
            // R11 R13 one pulse at a time, held low long enough
            cnv_n <= 1'b0;
            low_cnt <= low_req;
            state <= H_PULSE;
          end
        end
        H_WAIT: begin
          // R09 R14 select only after end-of-conversion
          if (!pending) begin
            cs_n <= 1'b0;
            din <= tx_sr[7];
            div_cnt <= 4'h0;
            bit_cnt <= 3'h0;
            state <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (half_done) begin
            div_cnt <= 4'h0;
            sclk <= !sclk;
            if (!sclk) begin
              rx_sr <= {rx_sr[14:0], pin_lvl[0]};
            end else begin
              tx_sr <= {tx_sr[6:0], 1'b0};
              din <= tx_sr[6];
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7) begin
                cs_n <= !keep;
                pending <= pending | arm;
                state <= H_GAP;
              end
            end
          end
        end
        H_PULSE: begin
          low_cnt <= low_cnt - 8'h1;
          if (low_cnt == 8'h1) begin
            cnv_n <= 1'b1;
            pending <= 1'b1;
            div_cnt <= 4'h0;
            state <= H_GAP;
          end
        end
        default: begin
          if (half_done) begin
            state <= H_IDLE;
          end
        end
      endcase
    end
  end

  assign link.sclk = sclk;
  assign link.cs_n = cs_n;
  assign link.din = din;
  assign link.convert_start_n = cnv_n;
endmodule
`default_nettype wire

// ==== tb/adc_link_props.sv ====
/*
  Link checker: timing relations between the converter and its host.
  Assumes both ends run on mclk and share rst_b.
*/
`timescale 1ns/100ps
`default_nettype none
module adc_link_props (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic convert_start_n,
  input wire logic eoc_n
);
  logic prev_cnv;
  logic prev_cs;
  logic prev_eoc;
  logic waiting;
  logic [7:0] since;

  // ****************************************
  // Helper state
  // ****************************************
  wire cnv_rise = !prev_cnv && convert_start_n;
  wire cs_rise = !prev_cs && cs_n;
  wire eoc_fall = prev_eoc && !eoc_n;

  // Open from a start pulse until end-of-conversion falls
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prev_cnv <= 1'b1;
      prev_cs <= 1'b1;
      prev_eoc <= 1'b1;
      waiting <= 1'b0;
      since <= 8'h00;
    end else begin
      prev_cnv <= convert_start_n;
      prev_cs <= cs_n;
      prev_eoc <= eoc_n;
      waiting <= cnv_rise | (waiting & !eoc_fall);
      since <= (cnv_rise | cs_rise) ? 8'h00 : since + {7'h00, since != 8'hFF};
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_cnv_low_min: assert property ($fell(convert_start_n) |-> !convert_start_n [*4])
    else $error("start pulse shorter than four cycles");
  a_wait_for_eoc: assert property (waiting |-> cs_n && convert_start_n)
    else $error("select or start driven before end of conversion");
  a_eoc_hold: assert property ($rose(eoc_n) |-> !$past(cs_n, 2) || !$past(convert_start_n, 2))
    else $error("end of conversion released without select or start");
  a_eoc_deselected: assert property ($fell(eoc_n) |-> cs_n)
    else $error("end of conversion fell while selected");
  a_eoc_not_early: assert property ($fell(eoc_n) |-> since >= 8'h5A)
    else $error("end of conversion sooner than one conversion time");
  a_sclk_framed: assert property (sclk |-> !cs_n)
    else $error("serial clock high while deselected");
  a_sclk_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high phase not eight cycles");
  a_din_on_low: assert property ($changed(din) |-> !sclk)
    else $error("host data changed while serial clock high");
  a_dout_on_low: assert property ($changed(dout) && !cs_n && !$past(cs_n) |-> !sclk)
    else $error("result data changed while serial clock high");
endmodule
`default_nettype wire

// ==== tb/adc_scan_average_sequencer_tb.sv ====
/*
  Bench for the scan sequencer: host and converter joined by the link,
  software side driven over Avalon-MM, converter input from the bench.
  Assumes the package, map header, interface and design files come first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module adc_scan_average_sequencer_tb;
  import adc_seq_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] sample_in = 12'h0;
  logic [3:0] mux_channel;
  logic temp_select;
  logic [11:0] cval = 12'h1;
  logic [11:0] tval = 12'h2;
  logic [31:0] q;
  logic prev_cs = 1'b1;
  logic prev_eoc = 1'b1;
  logic [7:0] avgs [5] = '{8'h33, 8'h36, 8'h39, 8'h3C, 8'h23};
  integer seed = 94192;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int t_cs = 0;
  int t_eoc = 0;

  adc_link_if link ();
  adc_device adc_device_i (.mclk(mclk), .rst_b(rst_b), .link(link.device), .sample_in(sample_in),
    .mux_channel(mux_channel), .temp_select(temp_select));
  adc_host adc_host_i (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link.host));
  adc_link_props adc_link_props_i (.mclk(mclk), .rst_b(rst_b), .sclk(link.sclk), .cs_n(link.cs_n),
    .din(link.din), .dout(link.dout), .convert_start_n(link.convert_start_n), .eoc_n(link.eoc_n));

  // ****************************************
  // Clock, converter input, timestamps, timeout
  // ****************************************
  always #5 mclk = ~mclk;

  always @(posedge mclk) begin
    sample_in <= temp_select ? tval : cval;
    prev_cs <= link.cs_n;
    prev_eoc <= link.eoc_n;
    cyc <= cyc + 1;
    if (link.cs_n && !prev_cs)
      t_cs <= cyc;
    if (!link.eoc_n && prev_eoc)
      t_eoc <= cyc;
    // Ceiling: about 80000 cycles of scans and reads, plus margin
    if (cyc == 95000) begin
      n_fail++;
      summarize();
    end
  end

  // ****************************************
  // Expectations
  // ****************************************
  function automatic int ndep(input logic [7:0] a);
    return a[4] ? 4 << a[3:2] : 1;
  endfunction

  function automatic int nres(input logic [7:0] a);
    return 4 * (a[1:0] + 1);
  endfunction

  // Conversions take one hundred and one cycles each, small slack for sync
  function automatic logic dur_ok(input int d, input int n);
    return (d >= n * 100 - 10) && (d <= n * 102 + 10);
  endfunction

  // ****************************************
  // Bus and link tasks
  // ****************************************
  task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do
      @(posedge mclk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic poll(input logic [3:0] m);
    do
      bus(1'b0, `REG_STATUS, 32'h0);
    while ((q[3:0] & m) !== 4'h0);
  endtask

  task automatic send(input logic [7:0] b, input logic [1:0] f);
    bus(1'b1, `REG_CMD, {22'h0, f, b});
    poll(4'h1);
  endtask

  task automatic rnd();
    cval <= 12'($random(seed)) | 12'h001;
    tval <= 12'($random(seed)) | 12'h800;
  endtask

  task automatic scan(input logic [7:0] b);
    rnd();
    send(b, 2'b10);
    poll(4'h2);
  endtask

  task automatic pulse(input logic [7:0] w);
    bus(1'b1, `REG_CNV, {24'h0, w});
    poll(4'h3);
  endtask

  task automatic got(input logic [15:0] e);
    send(8'h00, 2'b01);
    send(8'h00, 2'b00);
    bus(1'b0, `REG_RX, 32'h0);
    `CHK(q[15:0], e)
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    scan(8'hAE);
    `CHK(dur_ok(t_eoc - t_cs, 1), 1'b1)
    got({4'h0, cval});
    got(16'h0);
    scan(8'h91);
    `CHK(dur_ok(t_eoc - t_cs, 4), 1'b1)
    got({4'h0, tval});
    repeat (3) got({4'h0, cval});
    scan(8'hE2);
    `CHK(mux_channel, 4'hC)
    repeat (4) got({4'h0, cval});
    got(16'h0);
    for (int i = 0; i < 5; i++) begin
      send(avgs[i], 2'b00);
      scan({1'b1, 4'(i + 1), 3'b100});
      `CHK(dur_ok(t_eoc - t_cs, ndep(avgs[i]) * nres(avgs[i])), 1'b1)
      for (int k = 0; k < nres(avgs[i]); k++)
        got({4'h0, cval});
      got(16'h0);
    end
    scan(8'h84);
    send(8'h1F, 2'b00);
    got(16'h0);
    send(8'h40, 2'b00);
    send(8'h17, 2'b00);
    scan(8'hBC);
    `CHK(dur_ok(t_eoc - t_cs, 4), 1'b1)
    repeat (4) got({4'h0, cval});
    got(16'h0);
    send(8'h40, 2'b00);
    rnd();
    send(8'hCF, 2'b00);
    repeat (300) @(posedge mclk);
    bus(1'b0, `REG_STATUS, 32'h0);
    `CHK(q[2], 1'b1)
    pulse(8'h04);
    got({4'h0, tval});
    got({4'h0, cval});
    got(16'h0);
    send(8'h50, 2'b00);
    rnd();
    send(8'h97, 2'b00);
    pulse(8'h04);
    got({4'h0, tval});
    pulse(8'h8C);
    got({4'h0, cval});
    send(8'h30, 2'b00);
    send(8'h96, 2'b00);
    repeat (3) pulse(8'h8C);
    got(16'h0);
    pulse(8'h8C);
    got({4'h0, cval});
    summarize();
  end
endmodule
`default_nettype wire
